// ==== pldo_host.sv ====
`timescale 1ns/1ns
// serial bus host: drives the clock, pulls data low, reads the pulled-up line
module pldo_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low,
    output logic o_rd_stb,
    output logic [7:0] o_rd_byte,
    output logic o_ack
);
    int q = 5; // quarter bit in clocks, raised for a slow host
    // bus idle at time zero
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_rd_stb = 1'b0;
        o_rd_byte = 8'h00;
        o_ack = 1'b0;
    end
    // wait n quarters, then step off the clock edge
    task automatic wq(input int n);
        repeat (n * q) @(posedge i_clk);
        #1;
    endtask
    // one bit, clock low on entry and exit, data sampled late in the high half
    task automatic bit_io(input logic b, output logic s);
        wq(1);
        o_sda_low = ~b;
        wq(1);
        o_scl = 1'b1;
        wq(2);
        s = i_sda;
        o_scl = 1'b0;
    endtask
    // eight bits msb first, then the acknowledge clock
    task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] r,
                           output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ab, ak);
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic start();
        wq(1);
        o_sda_low = 1'b0;
        wq(1);
        o_scl = 1'b1;
        wq(2);
        o_sda_low = 1'b1;
        wq(2);
        o_scl = 1'b0;
    endtask
    // stop: data rises while the clock is high
    task automatic stop();
        wq(1);
        o_sda_low = 1'b1;
        wq(1);
        o_scl = 1'b1;
        wq(2);
        o_sda_low = 1'b0;
        wq(2);
    endtask
    // register write of one or two bytes, pointer advances in the device
    task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0,
                      input logic [7:0] d1);
        logic [7:0] r;
        logic k0, k1, k2, k3;
        start();
        byte_io({pldo_pkg::DEV_ADDR, 1'b0}, 1'b1, r, k0);
        byte_io(a, 1'b1, r, k1);
        byte_io(d0, 1'b1, r, k2);
        k3 = 1'b0;
        if (n > 1) begin
            byte_io(d1, 1'b1, r, k3);
        end
        o_ack = ~(k0 | k1 | k2 | k3);
        stop();
    endtask
    // register read, acks all but the last byte, each byte strobed out
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] r;
        logic k0, k1, k2, k;
        start();
        byte_io({pldo_pkg::DEV_ADDR, 1'b0}, 1'b1, r, k0);
        byte_io(a, 1'b1, r, k1);
        start();
        byte_io({pldo_pkg::DEV_ADDR, 1'b1}, 1'b1, r, k2);
        o_ack = ~(k0 | k1 | k2);
        for (int i = 1; i <= n; i++) begin
            byte_io(8'hFF, (i == n), r, k);
            o_rd_byte = r;
            o_rd_stb = 1'b1;
            @(posedge i_clk);
            #1;
            o_rd_stb = 1'b0;
        end
        stop();
    endtask
endmodule

// ==== pldo_pkg.sv ====
package pldo_pkg;
    // register addresses on the serial bus
    localparam logic [7:0] ADDR_THIRD_CTL = 8'h70;
    localparam logic [7:0] ADDR_FOURTH_CTL = 8'h71;
    localparam logic [7:0] ADDR_PAGE = 8'h7F;
    localparam logic [7:0] ADDR_EXT_INFO = 8'h80;

    // page select codes
    localparam logic [3:0] PAGE_FUNC = 4'h0;
    localparam logic [3:0] PAGE_EXT1 = 4'h1;
    localparam logic [3:0] PAGE_EXT2 = 4'h2;

    // control, page and event register field positions
    localparam int BIT_OFF_MODE = 7;
    localparam int BIT_LOWPOWER = 6;
    localparam int BIT_STANDBY = 5;
    localparam int BIT_ENABLE = 4;
    localparam int VCODE_MSB = 3;
    localparam int PAGE_MSB = 3;
    localparam int EVT_BIT = 0;

    // reset and fixed default values
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [3:0] PAGE_RST = 4'h0;
    localparam logic [4:0] FIXED_THIRD = 5'h10;
    localparam logic [4:0] FIXED_FOURTH = 5'h10;

    // pin synchroniser: bit 0 clock, 1 data, 2 button, 3 fuse supply
    localparam int SYNC_W = 4;
    localparam logic [3:0] SYNC_RST = 4'h3;

    // cycles after reset release before the fuse load
    localparam logic [1:0] LOAD_WAIT = 2'h3;

    // serial bus device address, value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h08;
    localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage

// ==== pldo_regs.sv ====
`timescale 1ns/1ns
// Behaviour
// (R1) third reg bit7: off or sleep after turn-off
// (R2) third reg bit6 permits low-power mode
// (R3) third reg bit5 switches off in standby
// (R4) third reg bit4 enables the regulator
// (R5) third reg bits3:0 voltage code out
// (R6) fourth reg bit7: off or sleep after turn-off
// (R7) fourth reg bit6 permits low-power mode
// (R8) fourth reg bit5 switches off in standby
// (R9) fourth reg bit4 enables the regulator
// (R10) fourth reg bits3:0 voltage code out
// (R11) page codes: functional, extended one, extended two
// (R12) addresses and data are eight bits
// (R13) only the first pages are reachable
// (R14) low half shared, high half per page
// (R15) host writes page code before extended access
// (R16) functional registers reachable from any page
// (R17) undefined addresses read zero, ignore writes
// (R18) write-one clears sticky bit, zero keeps
// (R19) fuse defaults loaded, writable after release
// (R20) control and page accessible any time; control writes are ignored until the fuse load ends
// (R21) button edge applies each off-or-sleep choice
// (R22) page holds value; unknown codes select nothing
module pldo_regs (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_power_button_input,
    input wire logic i_fuse_program_supply,
    input wire logic [4:0] i_third_fuse_bits,
    input wire logic [4:0] i_fourth_fuse_bits,
    output logic o_third_reg_off_or_sleep,
    output logic o_third_reg_lowpower_allow,
    output logic o_third_reg_standby_off,
    output logic o_third_reg_enable,
    output logic [3:0] o_third_reg_voltage_code,
    output logic o_third_reg_shutdown,
    output logic o_third_reg_asleep,
    output logic o_fourth_reg_off_or_sleep,
    output logic o_fourth_reg_lowpower_allow,
    output logic o_fourth_reg_standby_off,
    output logic o_fourth_reg_enable,
    output logic [3:0] o_fourth_reg_voltage_code,
    output logic o_fourth_reg_shutdown,
    output logic o_fourth_reg_asleep
);
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ACK_A = 9'h004,
        ST_REG = 9'h008,
        ST_ACK_R = 9'h010,
        ST_WDATA = 9'h020,
        ST_ACK_W = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK = 9'h100
    } pldo_st_e;
    logic [pldo_pkg::SYNC_W-1:0] sync_w;
    logic scl_q_r, sda_q_r, pb_q_r;
    logic bus_start, bus_stop, scl_rise, scl_fall;
    pldo_st_e st_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, ptr_r, wdata_r, rd_data;
    logic rw_r, host_wr_r;
    logic [1:0] load_cnt_r;
    logic load_pend_r, load_now, off_evt, evt_r;
    logic [3:0] page_r;
    logic wr_page, wr_evt;
    logic [1:0] wr_ctl, shut_r, sleep_r;
    logic [7:0] ctl_r [2];
    logic [4:0] fuse_sel [2];
    // pins pass two flip-flops before any logic sees them
    pldo_sync u_sync (
        .i_clk(i_clk), .i_rst(i_rst), .o_sync(sync_w),
        .i_async({i_fuse_program_supply, i_power_button_input, i_sda, i_scl})
    );

    // previous samples for edge detection
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            pb_q_r <= 1'b0;
        end else begin
            scl_q_r <= sync_w[0];
            sda_q_r <= sync_w[1];
            pb_q_r <= sync_w[2];
        end
    end
    // bus conditions and clock edges
    assign bus_start = sync_w[0] && scl_q_r && sda_q_r && !sync_w[1];
    assign bus_stop = sync_w[0] && scl_q_r && !sda_q_r && sync_w[1];
    assign scl_rise = sync_w[0] && !scl_q_r;
    assign scl_fall = !sync_w[0] && scl_q_r;
    assign off_evt = sync_w[2] && !pb_q_r; // R21
    // the data line is only ever pulled low
    always_ff @(posedge i_clk) begin
        o_sda <= 1'b0;
    end

    // serial slave: address byte, register pointer, data bytes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rw_r <= 1'b0;
            ptr_r <= 8'h00;
            host_wr_r <= 1'b0;
            wdata_r <= 8'h00;
            o_sda_oe <= 1'b0;
        end else begin
            host_wr_r <= 1'b0;
            if (bus_start) begin
                st_r <= ST_ADDR;
                cnt_r <= 4'h0;
                o_sda_oe <= 1'b0;
            end else if (bus_stop) begin
                st_r <= ST_IDLE;
                o_sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (st_r == ST_ADDR || st_r == ST_REG || st_r == ST_WDATA) begin
                    sh_r <= {sh_r[6:0], sync_w[1]};
                    cnt_r <= cnt_r + 4'h1;
                end else if (st_r == ST_RACK) begin
                    if (sync_w[1]) begin
                        st_r <= ST_IDLE; // master ends the read
                    end else begin
                        ptr_r <= ptr_r + 8'h01;
                    end
                end
            end else if (scl_fall) begin
                unique case (st_r)
                    ST_IDLE: begin
                    end
                    ST_ADDR: begin
                        if (cnt_r == pldo_pkg::BYTE_BITS) begin
                            if (sh_r[7:1] == pldo_pkg::DEV_ADDR) begin
                                o_sda_oe <= 1'b1;
                                rw_r <= sh_r[0];
                                st_r <= ST_ACK_A;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK_A, ST_RACK: begin
                        if (st_r == ST_RACK || rw_r) begin
                            o_sda_oe <= !rd_data[7];
                            sh_r <= {rd_data[6:0], 1'b0};
                            cnt_r <= 4'h1;
                            st_r <= ST_RDATA;
                        end else begin
                            o_sda_oe <= 1'b0;
                            cnt_r <= 4'h0;
                            st_r <= ST_REG;
                        end
                    end
                    ST_REG: begin
                        if (cnt_r == pldo_pkg::BYTE_BITS) begin
                            ptr_r <= sh_r; // R12
                            o_sda_oe <= 1'b1;
                            st_r <= ST_ACK_R;
                        end
                    end
                    ST_ACK_R, ST_ACK_W: begin
                        o_sda_oe <= 1'b0;
                        cnt_r <= 4'h0;
                        st_r <= ST_WDATA;
                        if (st_r == ST_ACK_W) begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end
                    ST_WDATA: begin
                        if (cnt_r == pldo_pkg::BYTE_BITS) begin
                            host_wr_r <= 1'b1;
                            wdata_r <= sh_r;
                            o_sda_oe <= 1'b1;
                            st_r <= ST_ACK_W;
                        end
                    end
                    ST_RDATA: begin
                        if (cnt_r == pldo_pkg::BYTE_BITS) begin
                            o_sda_oe <= 1'b0;
                            st_r <= ST_RACK;
                        end else begin
                            o_sda_oe <= !sh_r[7];
                            sh_r <= {sh_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // fuse load waits for the supply level to settle after release
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            load_cnt_r <= 2'h0;
            load_pend_r <= 1'b1;
        end else if (load_pend_r) begin
            if (load_cnt_r == pldo_pkg::LOAD_WAIT) begin
                load_pend_r <= 1'b0;
            end else begin
                load_cnt_r <= load_cnt_r + 2'h1;
            end
        end
    end
    assign load_now = load_pend_r && (load_cnt_r == pldo_pkg::LOAD_WAIT);
    // fixed defaults while the programming supply is present
    assign fuse_sel[0] = sync_w[3] ? pldo_pkg::FIXED_THIRD : i_third_fuse_bits; // R19
    assign fuse_sel[1] = sync_w[3] ? pldo_pkg::FIXED_FOURTH : i_fourth_fuse_bits; // R19

    // write decode; page register at any page, extended space follows the page code
    assign wr_page = host_wr_r && (ptr_r == pldo_pkg::ADDR_PAGE); // R20
    assign wr_evt = host_wr_r && (ptr_r == pldo_pkg::ADDR_EXT_INFO)
        && (page_r == pldo_pkg::PAGE_EXT1); // R14

    // page register keeps its code until rewritten
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            page_r <= pldo_pkg::PAGE_RST;
        end else if (wr_page) begin
            page_r <= wdata_r[pldo_pkg::PAGE_MSB:0]; // R11 R22
        end
    end

    // sticky turn-off event flag, an arriving event beats the clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            evt_r <= 1'b0;
        end else if (off_evt) begin
            evt_r <= 1'b1;
        end else if (wr_evt && wdata_r[pldo_pkg::EVT_BIT]) begin
            evt_r <= 1'b0; // R18
        end
    end

    // per regulator control register and turn-off state
    for (genvar g = 0; g < 2; g++) begin : g_reg
        localparam logic [7:0] CA = (g == 0) ? pldo_pkg::ADDR_THIRD_CTL
            : pldo_pkg::ADDR_FOURTH_CTL;
        assign wr_ctl[g] = host_wr_r && (ptr_r == CA) && !load_pend_r; // R19 R20
        // control byte: fuse load first, host writes after
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                ctl_r[g] <= pldo_pkg::CTL_RST;
            end else if (load_now) begin
                ctl_r[g][pldo_pkg::BIT_ENABLE:0] <= fuse_sel[g]; // R19
            end else if (wr_ctl[g]) begin
                ctl_r[g] <= wdata_r; // R2 R3 R4 R5 R7 R8 R9 R10
            end
        end

        // button event picks off or sleep; a rewrite of the register resumes
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                shut_r[g] <= 1'b0;
                sleep_r[g] <= 1'b0;
            end else if (off_evt) begin
                shut_r[g] <= !ctl_r[g][pldo_pkg::BIT_OFF_MODE]; // R1 R6 R21
                sleep_r[g] <= ctl_r[g][pldo_pkg::BIT_OFF_MODE]; // R1 R6 R21
            end else if (wr_ctl[g]) begin
                shut_r[g] <= 1'b0;
                sleep_r[g] <= 1'b0;
            end
        end
    end

    // read mux; low half ignores the page, unknown addresses read zero
    always_comb begin
        rd_data = 8'h00; // R17
        if (!ptr_r[7]) begin
            if (ptr_r == pldo_pkg::ADDR_PAGE) begin
                rd_data = {4'h0, page_r};
            end else if (ptr_r == pldo_pkg::ADDR_THIRD_CTL) begin
                rd_data = ctl_r[0]; // R16
            end else if (ptr_r == pldo_pkg::ADDR_FOURTH_CTL) begin
                rd_data = ctl_r[1]; // R16
            end
        end else if (ptr_r == pldo_pkg::ADDR_EXT_INFO) begin
            if (page_r == pldo_pkg::PAGE_EXT1) begin
                rd_data = {7'h00, evt_r}; // R13 R14
            end else if (page_r == pldo_pkg::PAGE_EXT2) begin
                rd_data = {4'h0, sleep_r[1], shut_r[1], sleep_r[0], shut_r[0]}; // R14
            end
        end
    end

    // regulator controls straight from the register flops
    assign o_third_reg_off_or_sleep = ctl_r[0][pldo_pkg::BIT_OFF_MODE]; // R1
    assign o_third_reg_lowpower_allow = ctl_r[0][pldo_pkg::BIT_LOWPOWER]; // R2
    assign o_third_reg_standby_off = ctl_r[0][pldo_pkg::BIT_STANDBY]; // R3
    assign o_third_reg_enable = ctl_r[0][pldo_pkg::BIT_ENABLE]; // R4
    assign o_third_reg_voltage_code = ctl_r[0][pldo_pkg::VCODE_MSB:0]; // R5
    assign o_third_reg_shutdown = shut_r[0];
    assign o_third_reg_asleep = sleep_r[0];
    assign o_fourth_reg_off_or_sleep = ctl_r[1][pldo_pkg::BIT_OFF_MODE]; // R6
    assign o_fourth_reg_lowpower_allow = ctl_r[1][pldo_pkg::BIT_LOWPOWER]; // R7
    assign o_fourth_reg_standby_off = ctl_r[1][pldo_pkg::BIT_STANDBY]; // R8
    assign o_fourth_reg_enable = ctl_r[1][pldo_pkg::BIT_ENABLE]; // R9
    assign o_fourth_reg_voltage_code = ctl_r[1][pldo_pkg::VCODE_MSB:0]; // R10
    assign o_fourth_reg_shutdown = shut_r[1];
    assign o_fourth_reg_asleep = sleep_r[1];
    // checks on the register bank behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_third_wr;
        host_wr_r && ptr_r == pldo_pkg::ADDR_THIRD_CTL && !load_pend_r;
    endsequence
    sequence s_fourth_wr;
        host_wr_r && ptr_r == pldo_pkg::ADDR_FOURTH_CTL && !load_pend_r;
    endsequence
    sequence s_load_done;
        $fell(load_pend_r);
    endsequence
    a_third_ctl_write: assert property ( // R2 R3 R4 R5 R20
        s_third_wr |=> o_third_reg_lowpower_allow == $past(wdata_r[6])
            && o_third_reg_standby_off == $past(wdata_r[5])
            && o_third_reg_enable == $past(wdata_r[4])
            && o_third_reg_voltage_code == $past(wdata_r[3:0]))
        else $error("third control write not applied");
    a_fourth_ctl_write: assert property ( // R7 R8 R9 R10 R20
        s_fourth_wr |=> o_fourth_reg_lowpower_allow == $past(wdata_r[6])
            && o_fourth_reg_standby_off == $past(wdata_r[5])
            && o_fourth_reg_enable == $past(wdata_r[4])
            && o_fourth_reg_voltage_code == $past(wdata_r[3:0]))
        else $error("fourth control write not applied");
    a_third_off_mode: assert property ( // R1 R21
        off_evt |=> o_third_reg_asleep == $past(ctl_r[0][7])
            && o_third_reg_shutdown == !$past(ctl_r[0][7]))
        else $error("third regulator wrong turn-off state");
    a_fourth_off_mode: assert property ( // R6 R21
        off_evt |=> o_fourth_reg_asleep == $past(ctl_r[1][7])
            && o_fourth_reg_shutdown == !$past(ctl_r[1][7]))
        else $error("fourth regulator wrong turn-off state");
    a_page_write_hold: assert property ( // R11 R22
        wr_page ##1 !wr_page [*2] |-> page_r == $past(wdata_r[3:0], 2))
        else $error("page code not held");
    a_unmapped_read_zero: assert property ( // R17
        !ptr_r[7] && ptr_r != pldo_pkg::ADDR_PAGE && ptr_r != pldo_pkg::ADDR_THIRD_CTL
            && ptr_r != pldo_pkg::ADDR_FOURTH_CTL |-> rd_data == 8'h00)
        else $error("undefined address reads nonzero");
    a_func_any_page: assert property ( // R14 R16
        ptr_r == pldo_pkg::ADDR_THIRD_CTL |-> rd_data == ctl_r[0])
        else $error("functional read depends on page");
    a_ext_no_page: assert property ( // R13 R14 R22
        ptr_r[7] && page_r > pldo_pkg::PAGE_EXT2 |-> rd_data == 8'h00)
        else $error("unknown page shows content");
    a_w1c_clear: assert property ( // R18
        wr_evt && wdata_r[0] && !off_evt |=> !evt_r)
        else $error("write one did not clear flag");
    a_w1c_keep: assert property ( // R18
        evt_r && wr_evt && !wdata_r[0] |=> evt_r)
        else $error("write zero cleared flag");
    a_otp_load: assert property ( // R19
        s_load_done |-> ctl_r[0][4:0] == $past(fuse_sel[0])
            && ctl_r[1][4:0] == $past(fuse_sel[1]) && ctl_r[0][7:5] == 3'h0)
        else $error("fuse defaults not loaded");
    a_load_blocks_write: assert property ( // R19
        load_pend_r && !load_now |=> $stable(ctl_r[0]) && $stable(ctl_r[1]))
        else $error("control changed before load");
endmodule

// ==== pldo_sync.sv ====
`timescale 1ns/1ns
// two flip-flop synchroniser for the asynchronous pins
module pldo_sync (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [pldo_pkg::SYNC_W-1:0] i_async,
    output logic [pldo_pkg::SYNC_W-1:0] o_sync
);
    logic [pldo_pkg::SYNC_W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_r <= pldo_pkg::SYNC_RST;
            o_sync <= pldo_pkg::SYNC_RST;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
// bench for the paged regulator control bank, reached through the bus host model
module tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic btn = 1'b0;
    logic supply = 1'b1;
    logic [4:0] fuse3 = 5'h00;
    logic [4:0] fuse4 = 5'h00;
    logic scl, sda_low, sda_o, sda_oe, rd_stb, h_ack;
    logic [7:0] rd_byte, v3, v4;
    logic t_oos, t_lp, t_sb, t_en, t_sd, t_as, f_oos, f_lp, f_sb, f_en, f_sd, f_as;
    logic [3:0] t_vc, f_vc;
    logic [7:0] expq[$];
    int seed = 32'hD73B;
    int errors = 0;
    int num_checks = 0;
    wire sda_w;
    wire [7:0] t_reg = {t_oos, t_lp, t_sb, t_en, t_vc};
    wire [7:0] f_reg = {f_oos, f_lp, f_sb, f_en, f_vc};
    wire [7:0] flags = {4'h0, f_as, f_sd, t_as, t_sd};
    // pulled-up data line, low when any party pulls it
    assign sda_w = ~(sda_low | (sda_oe & ~sda_o));
    always #5 i_clk = ~i_clk;
    pldo_regs dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_w), .o_sda(sda_o),
        .o_sda_oe(sda_oe), .i_power_button_input(btn), .i_fuse_program_supply(supply),
        .i_third_fuse_bits(fuse3), .i_fourth_fuse_bits(fuse4),
        .o_third_reg_off_or_sleep(t_oos), .o_third_reg_lowpower_allow(t_lp),
        .o_third_reg_standby_off(t_sb), .o_third_reg_enable(t_en),
        .o_third_reg_voltage_code(t_vc), .o_third_reg_shutdown(t_sd),
        .o_third_reg_asleep(t_as), .o_fourth_reg_off_or_sleep(f_oos),
        .o_fourth_reg_lowpower_allow(f_lp), .o_fourth_reg_standby_off(f_sb),
        .o_fourth_reg_enable(f_en), .o_fourth_reg_voltage_code(f_vc),
        .o_fourth_reg_shutdown(f_sd), .o_fourth_reg_asleep(f_as)
    );
    pldo_host u_host (
        .i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low),
        .o_rd_stb(rd_stb), .o_rd_byte(rd_byte), .o_ack(h_ack)
    );
    // compare and count
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // note the expected byte, then read it over the bus
    task automatic rx(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        u_host.rd(a, 1);
    endtask
    // single byte write, every byte must be acknowledged
    task automatic wx(input logic [7:0] a, input logic [7:0] d);
        u_host.wr(a, 1, d, 8'h00);
        chk("write ack", {7'h00, h_ack}, 8'h01);
    endtask
    // reset with fresh fuse values, then let the fuse load finish
    task automatic do_reset(input logic sup);
        @(posedge i_clk);
        #1;
        i_rst = 1'b1;
        supply = sup;
        fuse3 = 5'($random(seed));
        fuse4 = 5'($random(seed));
        repeat (8) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
    endtask
    // counts and verdict
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // each byte read takes the oldest note
    always @(posedge rd_stb) begin
        if (expq.size() == 0) begin
            errors++;
            $display("[ERR] read data expected none seen %h", rd_byte);
        end else begin
            chk("read data", rd_byte, expq.pop_front());
        end
    end
    // hang guard
    initial begin
        repeat (95000) @(posedge i_clk);
        errors++;
        $display("[ERR] run length expected under limit seen over");
        tally_and_finish();
    end
    // main sequence
    initial begin
        do_reset(1'b1);
        chk("third fixed default", t_reg, {3'b000, pldo_pkg::FIXED_THIRD});
        chk("fourth fixed default", f_reg, {3'b000, pldo_pkg::FIXED_FOURTH});
        rx(pldo_pkg::ADDR_THIRD_CTL, {3'b000, pldo_pkg::FIXED_THIRD});
        do_reset(1'b0);
        chk("third fuse default", t_reg, {3'b000, fuse3});
        chk("fourth fuse default", f_reg, {3'b000, fuse4});
        // burst writes drive every field out, burst reads return them
        for (int k = 0; k < 4; k++) begin
            v3 = (k == 0) ? 8'hFF : 8'($random(seed));
            v4 = (k == 0) ? 8'h00 : 8'($random(seed));
            u_host.wr(pldo_pkg::ADDR_THIRD_CTL, 2, v3, v4);
            chk("third outputs", t_reg, v3);
            chk("fourth outputs", f_reg, v4);
            expq.push_back(v3);
            expq.push_back(v4);
            u_host.rd(pldo_pkg::ADDR_THIRD_CTL, 2);
        end
        // page switching, shared low half, empty places
        wx(pldo_pkg::ADDR_PAGE, 8'h01);
        rx(pldo_pkg::ADDR_PAGE, 8'h01);
        rx(pldo_pkg::ADDR_FOURTH_CTL, v4);
        rx(pldo_pkg::ADDR_EXT_INFO, 8'h00);
        rx(8'h81, 8'h00);
        wx(8'h20, 8'hFF);
        rx(8'h20, 8'h00);
        wx(pldo_pkg::ADDR_PAGE, 8'h05);
        rx(pldo_pkg::ADDR_PAGE, 8'h05);
        rx(pldo_pkg::ADDR_EXT_INFO, 8'h00);
        // turn-off event: third set to sleep, fourth to off
        v3 = 8'h80 | 8'($random(seed));
        v4 = 8'h7F & 8'($random(seed));
        u_host.wr(pldo_pkg::ADDR_THIRD_CTL, 2, v3, v4);
        @(posedge i_clk);
        #1;
        btn = 1'b1;
        repeat (5) @(posedge i_clk);
        #1;
        chk("turn-off flags", flags, 8'h06);
        btn = 1'b0;
        u_host.q = 12; // slow host for this stretch
        wx(pldo_pkg::ADDR_PAGE, 8'h02);
        rx(pldo_pkg::ADDR_EXT_INFO, 8'h06);
        u_host.q = 5;
        wx(pldo_pkg::ADDR_PAGE, 8'h01);
        rx(pldo_pkg::ADDR_EXT_INFO, 8'h01);
        wx(pldo_pkg::ADDR_EXT_INFO, 8'h00);
        rx(pldo_pkg::ADDR_EXT_INFO, 8'h01);
        wx(pldo_pkg::ADDR_EXT_INFO, 8'h01);
        rx(pldo_pkg::ADDR_EXT_INFO, 8'h00);
        wx(pldo_pkg::ADDR_THIRD_CTL, v3);
        chk("flags after write", flags, 8'h04);
        wx(pldo_pkg::ADDR_PAGE, 8'h00);
        rx(pldo_pkg::ADDR_EXT_INFO, 8'h00);
        if (expq.size() != 0) begin
            errors++;
            $display("[ERR] pending reads expected 0 seen %0d", expq.size());
        end
        tally_and_finish();
    end
endmodule
